// ---- logic/sar_readout_pkg.sv ----
// constants and types of the three-wire converter readout
package sar_readout_pkg;
   localparam int CLK_PERIOD_NS = 25;
   localparam int CONV_TIME_NS = 1400;
   // longest time rounds down
   localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int WORD_BITS = 16;
   localparam logic [10:0] CONV_CNT_LAST = 11'(CONV_CYCLES - 1);
   localparam logic [4:0] NOBUSY_FALLS = 5'h10;
   localparam logic [4:0] BUSY_FALLS = 5'h11;
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CONVERT,
      ST_ACQUIRE
   } phase_t;
   typedef enum logic {
      MODE_CHIP_SELECT,
      MODE_CHAIN
   } iface_mode_t;
endpackage

// ---- logic/pin_sync.sv ----
// two-flop synchroniser for a group of pins
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end

   assign o_sync = sync_reg;
endmodule

// ---- logic/sar_three_wire_readout.sv ----
// conversion sequencer and serial readout in chip-select mode
module sar_three_wire_readout (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_convert_start_n_select,
   input wire logic i_serial_mode_select_input,
   input wire logic i_sclk,
   input wire logic i_sample_done,
   input wire logic [15:0] i_conv_result,
   output logic o_serial_result_output,
   output logic o_serial_result_output_oe,
   output logic o_sample_strobe,
   output logic o_powered_down,
   output logic o_chain_mode,
   output logic o_busy_mode
);
   // ----------------------------------------------------------------
   // pin synchronisation
   // ----------------------------------------------------------------
   logic [2:0] pins_sync;
   logic cnv_s;
   logic sdi_s;
   logic sclk_s;

   pin_sync #(.WIDTH(3)) u_sync (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      // start pin enters inverted: cleared flops then read as an idle
      // high pin, so leaving reset brings no false start rise
      .i_async({~i_convert_start_n_select,
         i_serial_mode_select_input,
         i_sclk}),
      .o_sync(pins_sync)
   );

   assign cnv_s = ~pins_sync[2];
   // mode pin is only looked at on a start rise
   assign sdi_s = pins_sync[1];
   assign sclk_s = pins_sync[0];

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   sar_readout_pkg::phase_t phase_reg, phase_next;
   // chip-select or chain, latched on each start rise outside conversion
   sar_readout_pkg::iface_mode_t mode_reg, mode_next;
   logic cnv_d_reg, cnv_d_next;
   logic sclk_d_reg, sclk_d_next;
   logic [10:0] conv_cnt_reg, conv_cnt_next;
   logic [15:0] result_reg, result_next;
   logic [16:0] shift_reg, shift_next;
   logic [4:0] falls_reg, falls_next;
   // busy choice stands until the next conversion ends
   logic busy_reg, busy_next;
   logic active_reg, active_next;
   logic oe_reg, oe_next;
   logic dout_reg, dout_next;
   logic strobe_reg, strobe_next;
   logic pd_reg, pd_next;
   logic chain_reg, chain_next;

   logic cnv_rise;
   logic cnv_fall;
   logic sclk_fall;
   logic [4:0] fall_limit;

   assign cnv_rise = cnv_s & ~cnv_d_reg;
   assign cnv_fall = ~cnv_s & cnv_d_reg;
   // each serial clock phase must span two or more mclk cycles, or
   // falls are lost; a shifted bit shows about three cycles after one
   assign sclk_fall = ~sclk_s & sclk_d_reg;
   // busy frames carry one extra leading bit
   assign fall_limit = busy_reg ? sar_readout_pkg::BUSY_FALLS
      : sar_readout_pkg::NOBUSY_FALLS;

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      phase_next = phase_reg;
      mode_next = mode_reg;
      cnv_d_next = cnv_s;
      sclk_d_next = sclk_s;
      conv_cnt_next = conv_cnt_reg;
      result_next = result_reg;
      shift_next = shift_reg;
      falls_next = falls_reg;
      busy_next = busy_reg;
      active_next = active_reg;
      oe_next = oe_reg;
      dout_next = dout_reg;
      strobe_next = 1'b0;
      pd_next = pd_reg;
      chain_next = chain_reg;

      case (phase_reg)
         sar_readout_pkg::ST_IDLE,
         sar_readout_pkg::ST_ACQUIRE: begin
            if (cnv_rise) begin
               // mode picked from select input at the start edge
               mode_next = sdi_s ? sar_readout_pkg::MODE_CHIP_SELECT
                  : sar_readout_pkg::MODE_CHAIN;
               chain_next = ~sdi_s;
               phase_next = sar_readout_pkg::ST_CONVERT;
               conv_cnt_next = '0;
               // one-cycle pulse to the sampling switch
               strobe_next = 1'b1;
               oe_next = 1'b0;
               active_next = 1'b0;
               pd_next = 1'b0;
            end else if (phase_reg == sar_readout_pkg::ST_ACQUIRE &&
                  mode_reg == sar_readout_pkg::MODE_CHIP_SELECT) begin
               if (cnv_s) begin
                  // start high ends any readout at once
                  oe_next = 1'b0;
                  active_next = 1'b0;
               end else if (cnv_fall && !busy_reg && !active_reg) begin
                  // start pin acts as select in three-wire use
                  active_next = 1'b1;
                  oe_next = 1'b1;
                  // with busy off, each frame restarts at the top of the stored word,
                  // but the start rise before a second select-low frame begins a new conversion
                  dout_next = result_reg[15];
                  shift_next = {result_reg[14:0], 2'h0};
                  falls_next = '0;
               end else if (active_reg && sclk_fall) begin
                  falls_next = falls_reg + 5'h01;
                  dout_next = shift_reg[16];
                  shift_next = {shift_reg[15:0], 1'b0};
                  if (falls_reg + 5'h01 == fall_limit) begin
                     oe_next = 1'b0;
                     active_next = 1'b0;
                  end
               end
            end
         end
         sar_readout_pkg::ST_CONVERT: begin
            // start edges here are ignored; timing is internal
            // the core may finish early; the count is the hard limit
            if (conv_cnt_reg == sar_readout_pkg::CONV_CNT_LAST ||
                  i_sample_done) begin
               phase_next = sar_readout_pkg::ST_ACQUIRE;
               pd_next = 1'b1;
               result_next = i_conv_result;
               falls_next = '0;
               if (mode_reg == sar_readout_pkg::MODE_CHIP_SELECT &&
                     !cnv_s) begin
                  // low start at end asks for the busy bit
                  // busy bit stands until the first serial clock fall
                  busy_next = 1'b1;
                  active_next = 1'b1;
                  oe_next = 1'b1;
                  dout_next = 1'b0;
                  shift_next = {i_conv_result, 1'b0};
               end else begin
                  // high start at end: no busy bit
                  // in chip-select mode readout then waits for the next select fall
                  busy_next = 1'b0;
                  active_next = 1'b0;
                  oe_next = 1'b0;
                  shift_next = {i_conv_result, 1'b0};
               end
            end else begin
               conv_cnt_next = conv_cnt_reg + 11'h001;
            end
         end
         default: begin
            // unused codes fall back to idle
            phase_next = sar_readout_pkg::ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      // synchronous reset: all outputs low until the first request
      if (i_reset) begin
         phase_reg <= sar_readout_pkg::ST_IDLE;
         mode_reg <= sar_readout_pkg::MODE_CHIP_SELECT;
         // start seen high so a pin high at release is no edge
         cnv_d_reg <= 1'b1;
         sclk_d_reg <= 1'b0;
         conv_cnt_reg <= '0;
         result_reg <= sar_readout_pkg::RESULT_RESET;
         shift_reg <= '0;
         falls_reg <= '0;
         busy_reg <= 1'b0;
         active_reg <= 1'b0;
         oe_reg <= 1'b0;
         dout_reg <= 1'b0;
         strobe_reg <= 1'b0;
         pd_reg <= 1'b0;
         chain_reg <= 1'b0;
      end else begin
         phase_reg <= phase_next;
         mode_reg <= mode_next;
         cnv_d_reg <= cnv_d_next;
         sclk_d_reg <= sclk_d_next;
         conv_cnt_reg <= conv_cnt_next;
         result_reg <= result_next;
         shift_reg <= shift_next;
         falls_reg <= falls_next;
         busy_reg <= busy_next;
         active_reg <= active_next;
         oe_reg <= oe_next;
         dout_reg <= dout_next;
         strobe_reg <= strobe_next;
         pd_reg <= pd_next;
         chain_reg <= chain_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs, each straight from its register
   // ----------------------------------------------------------------
   assign o_serial_result_output = dout_reg;
   assign o_serial_result_output_oe = oe_reg;
   assign o_sample_strobe = strobe_reg;
   assign o_powered_down = pd_reg;
   assign o_chain_mode = chain_reg;
   assign o_busy_mode = busy_reg;
endmodule

// ---- sim/sar_readout_checker.sv ----
// port assertions for the converter readout
module sar_readout_checker (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_convert_start_n_select,
   input wire logic o_serial_result_output,
   input wire logic o_serial_result_output_oe,
   input wire logic o_sample_strobe,
   input wire logic o_powered_down,
   input wire logic o_chain_mode,
   input wire logic o_busy_mode
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_reset);
   sample_quiet_a: assert property (
      o_sample_strobe |=> (!o_sample_strobe && !o_serial_result_output_oe)[*8])
      else $error("drive or restart in conversion");
   strobe_cause_a: assert property (
      o_sample_strobe |-> $past(i_convert_start_n_select))
      else $error("strobe without start");
   conv_power_a: assert property (
      o_sample_strobe |-> ##2 (!o_powered_down)[*8])
      else $error("powered down in conversion");
   conv_time_a: assert property (
      $rose(o_powered_down) |-> $past(o_sample_strobe, 56))
      else $error("conversion length wrong");
   end_enable_a: assert property (
      $rose(o_powered_down) |-> o_serial_result_output_oe == o_busy_mode)
      else $error("enable at end wrong");
   busy_bit_a: assert property (
      $rose(o_serial_result_output_oe) && o_busy_mode
         |-> !o_serial_result_output)
      else $error("busy bit not low");
   enable_cause_a: assert property (
      $rose(o_serial_result_output_oe) |-> !$past(i_convert_start_n_select, 2))
      else $error("enable while start high");
   cs_release_a: assert property (
      $rose(i_convert_start_n_select) |-> ##[1:5] !o_serial_result_output_oe)
      else $error("no release on start high");
   chain_silent_a: assert property (
      o_chain_mode |-> !o_serial_result_output_oe)
      else $error("data driven in chain mode");
   cover property ($rose(o_powered_down) && o_busy_mode);
   cover property ($fell(o_serial_result_output_oe) && !o_busy_mode);
   cover property ($rose(o_chain_mode));
endmodule
bind sar_three_wire_readout sar_readout_checker sar_readout_checker_inst (
   .i_mclk(i_mclk),
   .i_reset(i_reset),
   .i_convert_start_n_select(i_convert_start_n_select),
   .o_serial_result_output(o_serial_result_output),
   .o_serial_result_output_oe(o_serial_result_output_oe),
   .o_sample_strobe(o_sample_strobe),
   .o_powered_down(o_powered_down),
   .o_chain_mode(o_chain_mode),
   .o_busy_mode(o_busy_mode)
);

// ---- sim/sar_host_model.sv ----
// host side: serial clock bursts and bit capture
module sar_host_model (
   input wire logic i_go,
   input wire logic [4:0] i_falls,
   input wire logic i_sdo,
   output logic o_sclk,
   output logic [16:0] o_word,
   output logic o_done
);
   timeunit 1ns;
   timeprecision 100ps;
   // clock stands low between frames
   initial begin
      o_sclk = 1'b0;
      o_word = 17'h0;
      o_done = 1'b0;
   end
   always @(posedge i_go) begin
      o_done = 1'b0;
      o_word = 17'h0;
      repeat (i_falls) begin
         #100 o_sclk = 1'b1;
         o_word = {o_word[15:0], i_sdo};
         #100 o_sclk = 1'b0;
      end
      o_done = 1'b1;
   end
endmodule

// ---- sim/tb.sv ----
// self-checking bench for the converter readout
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_mclk = 1'b0, i_reset = 1'b1, cs_n = 1'b1, mode = 1'b1;
   logic go = 1'b0, serial_result_output, oe, stb, pd, chain, busy, sclk, done;
   logic [4:0] falls = 5'h10;
   logic [15:0] res = 16'hb5a3;
   logic [16:0] word;
   int fail_count = 0, compares = 0, cyc;
   wire logic [2:0] ev = {done, pd, stb};
   // released line shows the inverse of the last bit, never the bit
   wire logic sdo_pin = oe ? serial_result_output : ~serial_result_output;
   always #12.5 i_mclk = ~i_mclk;
   sar_three_wire_readout sar_three_wire_readout_inst (.i_mclk(i_mclk),
      .i_reset(i_reset), .i_convert_start_n_select(cs_n),
      .i_serial_mode_select_input(mode), .i_sclk(sclk), .i_sample_done(1'b0),
      .i_conv_result(res), .o_serial_result_output(serial_result_output),
      .o_serial_result_output_oe(oe), .o_sample_strobe(stb),
      .o_powered_down(pd), .o_chain_mode(chain), .o_busy_mode(busy));
   sar_host_model sar_host_model_inst (.i_go(go), .i_falls(falls),
      .i_sdo(sdo_pin), .o_sclk(sclk), .o_word(word), .o_done(done));
   task automatic results;
      if (fail_count == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [16:0] e, g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge i_mclk);
      #2;
   endtask
   task automatic wt(input int b);
      for (cyc = 1; cyc < 3000; cyc++) begin
         step(1);
         if (ev[b] === 1'b1) return;
      end
      fail_count++;
      results();
   endtask
   task automatic start(input logic m);
      cs_n = 1'b0;
      mode = m;
      step(4);
      cs_n = 1'b1;
      wt(0);
      chk("oe sample", 17'h0, 17'(oe));
   endtask
   task automatic burst(input logic [4:0] f);
      falls = f;
      go = 1'b1;
      wt(2);
      go = 1'b0;
   endtask
   task automatic no_busy;
      start(1'b1);
      step(10);
      cs_n = 1'b0;
      step(10);
      cs_n = 1'b1;
      wt(1);
      chk("conv cycles", 17'(sar_readout_pkg::CONV_CYCLES - 20),
         17'(cyc));
      chk("busy", 17'h0, {15'h0, busy, oe});
      cs_n = 1'b0;
      step(4);
      chk("msb", {15'h0, 1'b1, res[15]}, {15'h0, oe, serial_result_output});
      burst(5'h10);
      chk("word", 17'(res), {1'b0, word[15:0]});
      step(5);
      chk("oe 16", 17'h0, 17'(oe));
   endtask
   task automatic with_busy;
      start(1'b1);
      step(10);
      cs_n = 1'b0;
      wt(1);
      chk("busy start", 17'h6, {14'h0, busy, oe, serial_result_output});
      burst(5'h11);
      chk("word", {1'b0, res}, word);
      step(5);
      chk("oe 17", 17'h0, 17'(oe));
   endtask
   task automatic busy_abort;
      start(1'b1);
      step(10);
      cs_n = 1'b0;
      wt(1);
      burst(5'h08);
      step(1);
      chk("oe mid", 17'h1, 17'(oe));
      cs_n = 1'b1;
      // the rise also starts a fresh conversion: let it finish
      wt(0);
      chk("oe abort", 17'h0, 17'(oe));
      wt(1);
   endtask
   task automatic chain_run;
      start(1'b0);
      step(2);
      mode = 1'b1;
      wt(1);
      cs_n = 1'b0;
      step(5);
      chk("chain", 17'h2, {15'h0, chain, oe});
      start(1'b1);
      step(2);
      chk("cs mode", 17'h0, 17'(chain));
   endtask
   initial begin
      step(4);
      i_reset = 1'b0;
      step(3);
      no_busy();
      with_busy();
      busy_abort();
      chain_run();
      results();
   end
endmodule
